/* src/snfc_core.sv */
// command execution core of a serial nor flash
//
// What this block does
// - lock mode holds while the lock bit is set and the guard pin is low.
// - lock mode ends only by the guard pin going high.
// - control register writes are refused while lock mode holds.
// - read takes address on rising clock, data out on falling, address steps.
// - reads wrap from the top address to zero and keep streaming.
// - quick and dual reads are refused while a cycle runs.
// - dual read sends two bits per falling edge, address steps per byte.
// - dual output only for array reads, all else single bit.
// - sector wipe sets a 4K-byte sector to ones, high bits select it.
// - block wipe sets a 64K-byte block to ones, any inner address.
// - wipe and page write run only if select rises on a byte boundary.
// - cycle starts at select rise, busy flag held, then busy and latch clear.
// - sector and block wipes in the protected region are not run.
// - chip wipe runs only when the protect level is zero.
// - page write only clears bits to zero.
// - page write data wraps to the start of the same page.
// - beyond 256 bytes, only the last 256 are kept.
// - short page write leaves other page bytes unchanged.
// - page write to a protected page is refused.
// - in sleep only wake and signature read are taken.
// - sleep is entered a fixed delay after the ending select rise.
// - wake runs if select rises right after its eighth bit, or on a byte boundary of a signature read.
// - after reset the core is in standby, not asleep.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module snfc_core #(
  parameter int         ADDR_W  = 20,
  parameter int         TDP     = snfc_pkg::TDP_CYC,
  parameter logic [7:0] SIG_VAL = 8'h5A  // arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si_in,
  output logic            si_out,
  output logic            si_oe,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic       wp_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);
  localparam int MEM_N = 1 << ADDR_W;
  localparam int PG_N  = 1 << snfc_pkg::PAGE_W;

  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic [1:0] wp_s;
  logic       sck_d;
  logic       cs_d;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      sck_s <= 2'h0;
      cs_s  <= 2'h3;
      si_s  <= 2'h0;
      wp_s  <= 2'h3;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end
    else
    begin
      sck_s <= {sck_s[0], sclk};
      cs_s  <= {cs_s[0], cs_n};
      si_s  <= {si_s[0], si_in};
      wp_s  <= {wp_s[0], wp_n};
      sck_d <= sck_s[1];
      cs_d  <= cs_s[1];
    end

  wire sel     = ~cs_s[1];
  wire sck_r   = sel & sck_s[1] & ~sck_d;
  wire sck_f   = sel & ~sck_s[1] & sck_d;
  wire cs_rise = cs_s[1] & ~cs_d;

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  snfc_pkg::snfc_st_t st_q;
  logic [7:0]  op_q;
  logic [7:0]  shin_q;
  logic [2:0]  bit_q;
  logic [2:0]  nb_q;
  logic        acc_q;
  logic [23:0] addr_q;
  logic [7:0]  shout_q;
  logic [2:0]  ocnt_q;
  logic [7:0]  ctrl_q;
  logic        hwl_q;
  logic        wel_q;
  logic        wip_q;
  logic        pend_q;
  logic        dpd_q;
  logic [31:0] tdp_q;
  logic [ADDR_W-1:0] ex_a_q;
  logic [ADDR_W-1:0] ex_left_q;
  logic              ex_pgm_q;
  logic [7:0]  pofs_q;
  logic [7:0]  mem   [MEM_N];
  logic [7:0]  pbuf  [PG_N];
  logic        pmask [PG_N];

  // --------------------------------------------------
  // decode
  // --------------------------------------------------
  wire [7:0] byte_in = {shin_q[6:0], si_s[1]};
  wire       b_done  = sck_r & (bit_q == 3'h7);
  wire [3:0] bp      = ctrl_q[3:0];

  wire in_wr = (byte_in == snfc_pkg::OP_SECT) | (byte_in == snfc_pkg::OP_BLK)
             | (byte_in == snfc_pkg::OP_CHIP1) | (byte_in == snfc_pkg::OP_CHIP2)
             | (byte_in == snfc_pkg::OP_PAGE);
  wire in_adr = (byte_in == snfc_pkg::OP_READ) | (byte_in == snfc_pkg::OP_QUICK)
              | (byte_in == snfc_pkg::OP_DUAL) | (byte_in == snfc_pkg::OP_SECT)
              | (byte_in == snfc_pkg::OP_BLK) | (byte_in == snfc_pkg::OP_PAGE)
              | (byte_in == snfc_pkg::OP_WAKE);
  wire op_ok = dpd_q ? (byte_in == snfc_pkg::OP_WAKE)
             : (~wip_q & ~(in_wr & ~wel_q));

  wire is_sect = (op_q == snfc_pkg::OP_SECT);
  wire is_blk  = (op_q == snfc_pkg::OP_BLK);
  wire is_chip = (op_q == snfc_pkg::OP_CHIP1) | (op_q == snfc_pkg::OP_CHIP2);
  wire is_page = (op_q == snfc_pkg::OP_PAGE);
  wire is_dual = (op_q == snfc_pkg::OP_DUAL);
  wire is_wake = (op_q == snfc_pkg::OP_WAKE);

  // last output fall of a byte; the next load then sees the stepped address
  wire rd_step = sel & acc_q & (st_q == snfc_pkg::ST_RD) & sck_f
               & (ocnt_q == (is_dual ? 3'h6 : 3'h7));

  function automatic logic prot(input logic [ADDR_W-1:0] a, input logic [3:0] lvl);
    int nblk;
    int n;
    nblk = 1 << (ADDR_W - snfc_pkg::BLK_W);
    n    = (lvl == 4'h0) ? 0 : (1 << (lvl - 4'h1));
    prot = (lvl != 4'h0) && (int'(a[ADDR_W-1:snfc_pkg::BLK_W]) >= nblk - n);
  endfunction

  wire [ADDR_W-1:0] a_cur = addr_q[ADDR_W-1:0];
  wire on_byte = acc_q & (bit_q == 3'h0);
  wire go_wipe = on_byte & (is_sect | is_blk) & (nb_q == snfc_pkg::NB_ERASE)
               & ~prot(a_cur, bp);
  wire go_chip = on_byte & is_chip & (nb_q == snfc_pkg::NB_ONE)
               & (bp == 4'h0);
  wire go_page = on_byte & is_page & (nb_q >= snfc_pkg::NB_PAGE)
               & ~prot(a_cur, bp);
  wire go_ex   = cs_rise & (go_wipe | go_chip | go_page);
  wire go_arm  = cs_rise & on_byte & (op_q == snfc_pkg::OP_ARM)
               & (nb_q == snfc_pkg::NB_ONE);
  wire go_slp  = cs_rise & on_byte & (op_q == snfc_pkg::OP_SLEEP)
               & (nb_q == snfc_pkg::NB_ONE);
  wire go_wake = cs_rise & on_byte & is_wake
               & ((nb_q == snfc_pkg::NB_ONE) | (st_q == snfc_pkg::ST_RD));

  wire [ADDR_W-1:0] ex_msk =
      is_sect ? ADDR_W'((1 << snfc_pkg::SECT_W) - 1)
    : is_blk  ? ADDR_W'((1 << snfc_pkg::BLK_W) - 1)
    : is_chip ? {ADDR_W{1'b1}}
    :           ADDR_W'(PG_N - 1);

  // --------------------------------------------------
  // serial input and command sequencing
  // --------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      shin_q <= 8'h00;
      bit_q  <= 3'h0;
      nb_q   <= 3'h0;
    end
    else if (!sel)
    begin
      bit_q <= 3'h0;
      nb_q  <= 3'h0;
    end
    else if (sck_r)
    begin
      shin_q <= byte_in;
      bit_q  <= bit_q + 3'h1;
      if (b_done && nb_q != 3'h7)
        nb_q <= nb_q + 3'h1;
    end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      st_q   <= snfc_pkg::ST_OP;
      op_q   <= 8'h00;
      acc_q  <= 1'b0;
      addr_q <= 24'h0;
      pofs_q <= 8'h00;
    end
    else if (!sel)
    begin
      st_q  <= snfc_pkg::ST_OP;
      acc_q <= 1'b0;
    end
    else if (b_done)
      case (st_q)
        snfc_pkg::ST_OP:
        begin
          op_q  <= byte_in;
          acc_q <= op_ok;
          st_q  <= (op_ok & in_adr) ? snfc_pkg::ST_ADR : snfc_pkg::ST_IGN;
        end
        snfc_pkg::ST_ADR:
        begin
          addr_q <= {addr_q[15:0], byte_in};
          if (nb_q == snfc_pkg::NB_ADR)
          begin
            pofs_q <= byte_in;
            if (op_q == snfc_pkg::OP_READ || is_wake)
              st_q <= snfc_pkg::ST_RD;
            else if (op_q == snfc_pkg::OP_QUICK || is_dual)
              st_q <= snfc_pkg::ST_DUM;
            else if (is_page)
              st_q <= snfc_pkg::ST_PGM;
            else
              st_q <= snfc_pkg::ST_IGN;
          end
        end
        snfc_pkg::ST_DUM:
          st_q <= snfc_pkg::ST_RD;
        snfc_pkg::ST_PGM:
          pofs_q <= pofs_q + 8'h01;
        default:
          st_q <= st_q;
      endcase
    else if (rd_step)
      addr_q <= addr_q + 24'h1;

  // --------------------------------------------------
  // serial output on falling edges
  // --------------------------------------------------
  wire [7:0] ob = (ocnt_q != 3'h0) ? shout_q
                : is_wake ? SIG_VAL : mem[a_cur];
  wire rd_on = sel & acc_q & (st_q == snfc_pkg::ST_RD);

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      shout_q <= 8'h00;
      ocnt_q  <= 3'h0;
      so_out  <= 1'b0;
      si_out  <= 1'b0;
    end
    else if (!rd_on)
      ocnt_q <= 3'h0;
    else if (sck_f)
    begin
      so_out <= ob[7];
      if (is_dual)
      begin
        si_out  <= ob[6];
        shout_q <= {ob[5:0], 2'h0};
        ocnt_q  <= ocnt_q + 3'h2;
      end
      else
      begin
        shout_q <= {ob[6:0], 1'b0};
        ocnt_q  <= ocnt_q + 3'h1;
      end
    end

  // enable rises at the first data fall, so a refused read never drives
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      so_oe <= 1'b0;
    else
      so_oe <= rd_on & (so_oe | sck_f);

  assign si_oe = so_oe & is_dual;

  // --------------------------------------------------
  // page buffer
  // --------------------------------------------------
  // a refused opcode during a running program must not wipe its byte mask
  wire pg_clr = b_done & (st_q == snfc_pkg::ST_OP) & ~wip_q;
  wire pg_wr  = b_done & (st_q == snfc_pkg::ST_PGM) & acc_q;

  for (genvar i = 0; i < PG_N; i++)
  begin : g_pg
    always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
        pbuf[i]  <= 8'hFF;
        pmask[i] <= 1'b0;
      end
      else if (pg_clr)
        pmask[i] <= 1'b0;
      else if (pg_wr && pofs_q == 8'(i))
      begin
        pbuf[i]  <= byte_in;
        pmask[i] <= 1'b1;
      end
  end

  // --------------------------------------------------
  // self-timed cycle and array
  // --------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      wip_q     <= 1'b0;
      wel_q     <= 1'b0;
      ex_a_q    <= '0;
      ex_left_q <= '0;
      ex_pgm_q  <= 1'b0;
    end
    else if (wip_q)
    begin
      ex_a_q    <= ex_a_q + ADDR_W'(1);
      ex_left_q <= ex_left_q - ADDR_W'(1);
      if (ex_left_q == '0)
      begin
        wip_q <= 1'b0;
        wel_q <= 1'b0;
      end
    end
    else if (go_ex)
    begin
      wip_q     <= 1'b1;
      ex_a_q    <= a_cur & ~ex_msk;
      ex_left_q <= ex_msk;
      ex_pgm_q  <= is_page;
    end
    else if (go_arm)
      wel_q <= 1'b1;

  // array write walks one byte per cycle; slow but keeps one write port
  wire [7:0] pidx = ex_a_q[7:0];
  wire [7:0] mval = ex_pgm_q ? (pmask[pidx] ? (mem[ex_a_q] & pbuf[pidx])
                                            : mem[ex_a_q])
                             : 8'hFF;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      for (int k = 0; k < MEM_N; k++)
        mem[k] <= 8'hFF;
    end
    else if (wip_q)
      mem[ex_a_q] <= mval;

  // --------------------------------------------------
  // sleep
  // --------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      pend_q <= 1'b0;
      dpd_q  <= 1'b0;
      tdp_q  <= 32'h0;
    end
    else if (go_wake)
    begin
      pend_q <= 1'b0;
      dpd_q  <= 1'b0;
    end
    else if (go_slp && !dpd_q)
    begin
      pend_q <= 1'b1;
      tdp_q  <= 32'(TDP);
    end
    else if (pend_q)
    begin
      tdp_q <= tdp_q - 32'h1;
      if (tdp_q <= 32'h1)
      begin
        pend_q <= 1'b0;
        dpd_q  <= 1'b1;
      end
    end

  // --------------------------------------------------
  // register port
  // --------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      ctrl_q <= snfc_pkg::CTRL_RST;
      hwl_q  <= 1'b0;
    end
    else
    begin
      hwl_q <= ctrl_q[snfc_pkg::CTRL_LOCK] & ~wp_s[1];
      if (reg_wr && reg_addr == snfc_pkg::REG_CTRL && !hwl_q)
        ctrl_q <= reg_wdata & 8'h8F;
    end

  wire [7:0] stat_v = {4'h0, dpd_q, hwl_q, wel_q, wip_q};

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= (reg_addr == snfc_pkg::REG_CTRL) ? ctrl_q
                 : (reg_addr == snfc_pkg::REG_STAT) ? stat_v : 8'h00;
    else
      reg_rdata <= 8'h00;

endmodule // snfc_core

`default_nettype wire

/* src/snfc_pkg.sv */
// constants and types of the serial nor flash command core
package snfc_pkg;
  localparam int CLK_NS  = 8;
  localparam int T_DP_NS = 10000;
  localparam int TDP_CYC = (T_DP_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_QUICK = 8'h0B;
  localparam logic [7:0] OP_DUAL  = 8'h3B;
  localparam logic [7:0] OP_ARM   = 8'h06;
  localparam logic [7:0] OP_SECT  = 8'h20;
  localparam logic [7:0] OP_BLK   = 8'hD8;
  localparam logic [7:0] OP_CHIP1 = 8'h60;
  localparam logic [7:0] OP_CHIP2 = 8'hC7;
  localparam logic [7:0] OP_PAGE  = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE  = 8'hAB;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam int CTRL_LOCK = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int STAT_WIP  = 0;
  localparam int STAT_WEL  = 1;
  localparam int STAT_HWL  = 2;
  localparam int STAT_DPD  = 3;

  localparam int SECT_W = 12;
  localparam int BLK_W  = 16;
  localparam int PAGE_W = 8;
  localparam logic [2:0] NB_ERASE = 3'h4;
  localparam logic [2:0] NB_PAGE  = 3'h5;
  localparam logic [2:0] NB_ONE   = 3'h1;
  localparam logic [2:0] NB_ADR   = 3'h3;
  localparam logic [2:0] NB_DUM   = 3'h4;

  typedef enum logic [5:0] {
    ST_OP  = 6'h01,
    ST_ADR = 6'h02,
    ST_DUM = 6'h04,
    ST_RD  = 6'h08,
    ST_PGM = 6'h10,
    ST_IGN = 6'h20
  } snfc_st_t;
endpackage

/* tb/snfc_core_properties.sv */
// checker of the serial nor flash command core ports
`timescale 1ns/1ps
`default_nettype none

module snfc_core_props (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       si_in,
  input wire logic       si_out,
  input wire logic       si_oe,
  input wire logic       so_out,
  input wire logic       so_oe,
  input wire logic       wp_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ----
  // helper counters, saturating so they never wrap into a false pass
  // ----
  logic [2:0] cs_hi_cnt;
  logic [2:0] wp_hi_cnt;
  logic [3:0] fall_cnt;
  logic       sclk_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_hi_cnt <= 3'h0;
      wp_hi_cnt <= 3'h0;
      fall_cnt  <= 4'hF;
      sclk_q    <= 1'b0;
    end
    else
    begin
      cs_hi_cnt <= cs_n ? cs_hi_cnt + {2'h0, cs_hi_cnt != 3'h7} : 3'h0;
      wp_hi_cnt <= wp_n ? wp_hi_cnt + {2'h0, wp_hi_cnt != 3'h7} : 3'h0;
      fall_cnt  <= (sclk_q && !sclk) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hF};
      sclk_q    <= sclk;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence stat_rd;
    reg_rd && reg_addr == snfc_pkg::REG_STAT;
  endsequence

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  chk_busy_latch: assert property (stat_rd |=> !reg_rdata[0] || reg_rdata[1])
    else $error("busy without write latch");
  chk_sleep_busy: assert property (stat_rd |=> !(reg_rdata[3] && reg_rdata[0]))
    else $error("asleep while busy");
  chk_guard_free: assert property (stat_rd ##0 wp_hi_cnt >= 3'h5 |=> !reg_rdata[2])
    else $error("lock mode with guard high");
  chk_dual_only: assert property (si_oe |-> so_oe)
    else $error("io0 driven outside dual read");
  chk_oe_quiet: assert property (cs_hi_cnt >= 3'h6 |-> !so_oe && !si_oe)
    else $error("output driven after deselect");
  chk_oe_start: assert property ($rose(so_oe) |-> cs_hi_cnt == 3'h0)
    else $error("output enabled while deselected");
  chk_out_edge: assert property (so_oe && $past(so_oe) && $changed(so_out)
                                 |-> fall_cnt <= 4'h7)
    else $error("data changed away from falling edge");
endmodule // snfc_core_props

bind snfc_core snfc_core_props chk_u (
  .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .si_in(si_in),
  .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

`default_nettype wire

/* tb/snfc_host.sv */
// host serial controller model for the link
`timescale 1ns/1ps
`default_nettype none

module snfc_host (
  input  wire logic io0,
  input  wire logic io1,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  // ----
  // mode 0 master, clock stands low outside frames
  // ----
  localparam realtime HALF = 62.5;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic sel();
    #HALF cs_n = 1'b0;
  endtask

  // released data line shows the inverse, not a stale value
  task automatic desel();
    #HALF cs_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask

  // nb below 8 cuts a unit short on purpose
  task automatic xfer(input logic [7:0] tx, input int nb, input logic dual,
                      output logic [7:0] rx);
    int i;
    i = 7;
    rx = 8'h00;
    while (i >= 8 - nb)
    begin
      mosi = tx[i];
      #HALF sclk = 1'b1;
      rx[i] = io1;
      if (dual)
      begin
        rx[i-1] = io0;
        i = i - 1;
      end
      i = i - 1;
      #HALF sclk = 1'b0;
    end
  endtask
endmodule // snfc_host

`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the serial nor flash command core
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       ref_clk, rstn, wp_n, reg_wr, reg_rd, oe_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, s;
  wire  logic sclk, cs_n, mosi, si_out, si_oe, so_out, so_oe, io0, io1;
  wire  logic [7:0] reg_rdata;
  int         errors, checked, cyc;
  logic [7:0] q[$];

  assign io0 = si_oe ? si_out : mosi;
  // released so line rests high on its board pull-up
  assign io1 = so_oe ? so_out : 1'b1;

  snfc_core #(.ADDR_W(17), .TDP(4)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .si_in(io0),
    .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  snfc_host host_u (.io0(io0), .io1(io1), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (so_oe === 1'b1)
      oe_seen = 1'b1;
    if (cyc == 90000)
    begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // ----
  // shared tasks
  // ----
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked = checked + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic creg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk("register", e, d & m);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na);
    logic [7:0] r;
    host_u.sel();
    host_u.xfer(op, 8, 1'b0, r);
    for (int k = 0; k < na; k++)
      host_u.xfer(a[23-8*k -: 8], 8, 1'b0, r);
  endtask

  task automatic arm();
    cmd(snfc_pkg::OP_ARM, 24'h000000, 0);
    host_u.desel();
  endtask

  task automatic pw(input logic [23:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    cmd(snfc_pkg::OP_PAGE, a, 3);
    foreach (d[k])
      host_u.xfer(d[k], 8, 1'b0, r);
    host_u.desel();
  endtask

  task automatic rf(input logic [7:0] op, input logic [23:0] a, input logic dual,
                    input logic [7:0] e[$]);
    logic [7:0] r;
    cmd(op, a, 3);
    if (op != snfc_pkg::OP_READ)
      host_u.xfer(8'h00, 8, 1'b0, r);
    foreach (e[k])
    begin
      host_u.xfer(8'h00, 8, dual, r);
      chk("flash", e[k], r);
    end
    host_u.desel();
  endtask

  // bounded poll; a stuck busy flag shows as a mismatch
  task automatic idle();
    logic [7:0] d;
    d = 8'hFF;
    for (int i = 0; i < 4000 && d[0] !== 1'b0; i++)
      rd(snfc_pkg::REG_STAT, d);
    chk("status", 8'h00, d);
  endtask

  // ----
  // test sequence
  // ----
  initial
  begin
    {ref_clk, rstn, wp_n, reg_wr, reg_rd, oe_seen} = 6'h08;
    {reg_addr, reg_wdata, errors, checked, cyc} = '0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    creg(snfc_pkg::REG_STAT, 8'hFF, 8'h00);
    creg(snfc_pkg::REG_CTRL, 8'hFF, 8'h00);
    creg(4'hF, 8'hFF, 8'h00);
    $display("test reset done");
    pw(24'h000010, '{8'h12});
    creg(snfc_pkg::REG_STAT, 8'hFF, 8'h00);
    rf(snfc_pkg::OP_READ, 24'h000010, 1'b0, '{8'hFF});
    arm();
    creg(snfc_pkg::REG_STAT, 8'hFF, 8'h02);
    pw(24'h0000FE, '{8'hA5, 8'h3C, 8'h0F});
    creg(snfc_pkg::REG_STAT, 8'hFF, 8'h03);
    idle();
    rf(snfc_pkg::OP_READ, 24'h0000FE, 1'b0, '{8'hA5, 8'h3C});
    rf(snfc_pkg::OP_READ, 24'h000000, 1'b0, '{8'h0F, 8'hFF});
    rf(snfc_pkg::OP_READ, 24'h01FFFF, 1'b0, '{8'hFF, 8'h0F});
    arm();
    pw(24'h0000FE, '{8'hF0});
    idle();
    rf(snfc_pkg::OP_READ, 24'h0000FE, 1'b0, '{8'hA0});
    arm();
    cmd(snfc_pkg::OP_PAGE, 24'h0000FE, 3);
    host_u.xfer(8'h00, 8, 1'b0, s);
    host_u.xfer(8'h00, 4, 1'b0, s);
    host_u.desel();
    rf(snfc_pkg::OP_READ, 24'h0000FE, 1'b0, '{8'hA0});
    $display("test page done");
    arm();
    for (int k = 0; k < 257; k++)
      q.push_back(k[7:0] ^ {k[8], 7'h00});
    pw(24'h001000, q);
    idle();
    rf(snfc_pkg::OP_READ, 24'h001000, 1'b0, '{8'h80, 8'h01});
    arm();
    cmd(snfc_pkg::OP_SECT, 24'h000ABC, 3);
    host_u.desel();
    for (int i = 0; i < 2; i++)
    begin
      oe_seen = 1'b0;
      rf(i ? snfc_pkg::OP_DUAL : snfc_pkg::OP_QUICK, 24'h001000, i[0],
         '{i ? 8'hAA : 8'hFF});
      chk("refused", 8'h00, 8'(oe_seen));
    end
    idle();
    rf(snfc_pkg::OP_READ, 24'h0000FE, 1'b0, '{8'hFF});
    rf(snfc_pkg::OP_DUAL, 24'h001000, 1'b1, '{8'h80, 8'h01});
    rf(snfc_pkg::OP_QUICK, 24'h001000, 1'b0, '{8'h80, 8'h01});
    $display("test erase done");
    wr(snfc_pkg::REG_CTRL, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      arm();
      cmd(i == 0 ? snfc_pkg::OP_BLK : (i == 1 ? snfc_pkg::OP_CHIP1 : snfc_pkg::OP_CHIP2),
          24'h01ABCD, i == 0 ? 3 : 0);
      host_u.desel();
      creg(snfc_pkg::REG_STAT, 8'h01, 8'h00);
    end
    pw(24'h01ABCD, '{8'h00});
    creg(snfc_pkg::REG_STAT, 8'h01, 8'h00);
    rf(snfc_pkg::OP_READ, 24'h01ABCD, 1'b0, '{8'hFF});
    rf(snfc_pkg::OP_READ, 24'h001000, 1'b0, '{8'h80});
    $display("test protect done");
    wr(snfc_pkg::REG_CTRL, 8'h80);
    wp_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    creg(snfc_pkg::REG_STAT, 8'h04, 8'h04);
    wr(snfc_pkg::REG_CTRL, 8'h00);
    creg(snfc_pkg::REG_CTRL, 8'hFF, 8'h80);
    wp_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    creg(snfc_pkg::REG_STAT, 8'h04, 8'h00);
    wr(snfc_pkg::REG_CTRL, 8'h00);
    creg(snfc_pkg::REG_CTRL, 8'hFF, 8'h00);
    $display("test lock done");
    cmd(snfc_pkg::OP_SLEEP, 24'h000000, 0);
    host_u.desel();
    creg(snfc_pkg::REG_STAT, 8'h08, 8'h08);
    arm();
    pw(24'h000000, '{8'h00});
    creg(snfc_pkg::REG_STAT, 8'h09, 8'h08);
    cmd(snfc_pkg::OP_WAKE, 24'h000000, 0);
    host_u.xfer(8'h00, 1, 1'b0, s);
    host_u.desel();
    creg(snfc_pkg::REG_STAT, 8'h08, 8'h08);
    cmd(snfc_pkg::OP_WAKE, 24'h000000, 0);
    host_u.desel();
    creg(snfc_pkg::REG_STAT, 8'h08, 8'h00);
    rf(snfc_pkg::OP_READ, 24'h000000, 1'b0, '{8'hFF});
    $display("test sleep done");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
